/* rtl/ptlm_pkg.sv */
// Constants and types of the port transmit lockup monitor
package ptlm_pkg;
  localparam int NUM_PORTS = 7;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BLK_W = 11;
  localparam int PORT_W = 3;
  // Global register offsets
  localparam logic [15:0] ADDR_TAG0 = 16'h0000;
  localparam logic [15:0] ADDR_TAG1 = 16'h0001;
  localparam logic [15:0] ADDR_SOFT_RESET = 16'h0003;
  localparam logic [15:0] ADDR_LOOKUP_CTRL = 16'h0310;
  localparam logic [15:0] ADDR_PM_USAGE = 16'h03ac;
  // Per-port offsets, port number in address bits 15:12
  localparam logic [11:0] PORT_RX_DISCARD = 12'h0a00;
  localparam logic [11:0] PORT_TX_DISCARD = 12'h0a04;
  localparam logic [11:0] PORT_TX_UNICAST = 12'h0a08;
  localparam logic [11:0] PORT_TXQ_USAGE = 12'h0a10;
  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int VLAN_ENABLE_BIT = 7;
  localparam int FREE_LSB = 16;
  localparam int TXQ_LSB = 0;
  // Reset values and limits of the block counts
  localparam logic [BLK_W-1:0] FREE_BLOCKS_IDLE = 11'h07e8;
  localparam logic [BLK_W-1:0] TXQ_CAPACITY = 11'h0204;
  localparam logic [BLK_W-1:0] FREE_NORMAL_MIN = 11'h0580;
  localparam logic [BLK_W-1:0] TXQ_NORMAL_MAX = 11'h0200;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CNT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } ptlm_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [PORT_W-1:0] srcPort;
    logic [PORT_W-1:0] destPort;
  } ptlm_frame_t;
endpackage

/* rtl/ptlm_port_tx_lockup_monitor.sv */
// Switch core slice: per-port transmit queues, lockup latch, drop counters, registers
module ptlm_port_tx_lockup_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire ptlm_pkg::ptlm_reg_req_t regReq,
  output logic [ptlm_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  input wire ptlm_pkg::ptlm_frame_t ingress,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] halfDuplex,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] lockupTrigger,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] txSlot,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] pauseSent,
  output logic [ptlm_pkg::NUM_PORTS-1:0] txEnable,
  output logic fwdBlocked
);
  import ptlm_pkg::*;

  localparam int NP = NUM_PORTS;

  // Port register hit: port field p+1 and matching low offset
  function automatic logic portHit(input logic [ADDR_W-1:0] a, input int p,
                                   input logic [11:0] off);
    return (a[15:12] == 4'(p + 1)) && (a[11:0] == off);
  endfunction

  // Port number validity flag: true for 1..NP, false for zero
  function automatic logic portOk(input logic [PORT_W-1:0] n);
    return (n != 3'h0) && (int'(n) <= NP);
  endfunction

  // Port number field addresses table index p
  function automatic logic portIs(input logic [PORT_W-1:0] n, input int p);
    return int'(n) == p + 1;
  endfunction

  // Write strobe aimed at one register address
  function automatic logic wrHit(input ptlm_reg_req_t r, input logic [ADDR_W-1:0] a);
    return r.wrEn && (r.addr == a);
  endfunction

  // Host visible control registers
  logic softReset_q;
  logic [7:0] lookupCtrl_q;
  logic [7:0] defTag0_q;
  logic [7:0] defTag1_q;

  // Port and packet memory state
  logic [NP-1:0] locked_q;
  logic [NP-1:0] locked_d;
  logic [BLK_W-1:0] used_q [NP];
  logic [BLK_W-1:0] used_d [NP];
  logic [BLK_W-1:0] free_q;
  logic [BLK_W-1:0] free_d;

  // Statistics counters
  logic [DATA_W-1:0] rxDrop_q [NP];
  logic [DATA_W-1:0] txDrop_q [NP];
  logic [DATA_W-1:0] txUni_q [NP];

  // Per-cycle strobes
  logic [NP-1:0] enq;
  logic [NP-1:0] deq;
  logic [NP-1:0] rxDropHit;
  logic [NP-1:0] txDropHit;
  logic [PORT_W-1:0] deqCnt;
  logic [DATA_W-1:0] rd_d;
  logic vlanEn;

  assign vlanEn = lookupCtrl_q[VLAN_ENABLE_BIT];

  // Soft reset holds queues, locks and tags clear and the free count at FREE_BLOCKS_IDLE while the bit is one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      softReset_q <= 1'b0;
    end else if (wrHit(regReq, ADDR_SOFT_RESET)) begin
      softReset_q <= regReq.wrData[SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lookupCtrl_q <= CTRL_RESET;
    end else if (wrHit(regReq, ADDR_LOOKUP_CTRL)) begin
      lookupCtrl_q <= regReq.wrData[7:0];
    end
  end

  // Default tag 0 keeps its value until written or wiped by soft reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      defTag0_q <= CTRL_RESET;
    end else if (softReset_q) begin
      defTag0_q <= CTRL_RESET;
    end else if (wrHit(regReq, ADDR_TAG0)) begin
      defTag0_q <= regReq.wrData[7:0];
    end
  end

  // Default tag 1 behaves the same at its own address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      defTag1_q <= CTRL_RESET;
    end else if (softReset_q) begin
      defTag1_q <= CTRL_RESET;
    end else if (wrHit(regReq, ADDR_TAG1)) begin
      defTag1_q <= regReq.wrData[7:0];
    end
  end

  // Frame admission for the one ingress frame per cycle
  always_comb begin
    enq = '0;
    rxDropHit = '0;
    txDropHit = '0;
    for (int p = 0; p < NP; p++) begin
      if (ingress.valid && !softReset_q && portOk(ingress.srcPort)
          && portOk(ingress.destPort)) begin
        if (free_q == '0) begin
          if (portIs(ingress.srcPort, p)) begin
            rxDropHit[p] = 1'b1;
          end
        end else if (portIs(ingress.destPort, p)) begin
          if (used_q[p] >= TXQ_CAPACITY) begin
            txDropHit[p] = 1'b1;
          end else begin
            enq[p] = 1'b1;
          end
        end
      end
    end
  end

  // Egress: a locked port never drains its queue
  always_comb begin
    deqCnt = '0;
    for (int p = 0; p < NP; p++) begin
      deq[p] = txSlot[p] && !locked_q[p] && used_q[p] != '0
               && !softReset_q;
      deqCnt = deqCnt + PORT_W'(deq[p]);
      used_d[p] = used_q[p] + BLK_W'(enq[p]) - BLK_W'(deq[p]);
    end
    free_d = free_q - BLK_W'(|enq) + BLK_W'(deqCnt);
    if (softReset_q) begin
      free_d = FREE_BLOCKS_IDLE;
    end
  end

  // Lockup latch: only half duplex with VLAN on; only reset clears it
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      if (softReset_q) begin
        locked_d[p] = 1'b0;
      end else begin
        locked_d[p] = locked_q[p]
                      || (lockupTrigger[p] && halfDuplex[p] && vlanEn);
      end
    end
  end

  // Lock state per port; only a hard or soft reset releases it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_q <= '0;
    end else begin
      locked_q <= locked_d;
    end
  end

  // Transmitter enable mirrors the next lock state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txEnable <= '1;
    end else begin
      txEnable <= ~locked_d;
    end
  end

  // Free block count of the shared packet memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_q <= FREE_BLOCKS_IDLE;
    end else begin
      free_q <= free_d;
    end
  end

  // Forwarding stops while no free block is left
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwdBlocked <= 1'b0;
    end else begin
      fwdBlocked <= (free_d == '0);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : gPort
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          used_q[g] <= '0;
        end else if (softReset_q) begin
          used_q[g] <= '0;
        end else begin
          used_q[g] <= used_d[g];
        end
      end

      // Receive discards move only on drops, so they idle at zero
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          rxDrop_q[g] <= CNT_RESET;
        end else begin
          rxDrop_q[g] <= rxDrop_q[g] + DATA_W'(rxDropHit[g]);
        end
      end

      // Transmit discards likewise rise only on a full queue
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          txDrop_q[g] <= CNT_RESET;
        end else begin
          txDrop_q[g] <= txDrop_q[g] + DATA_W'(txDropHit[g]);
        end
      end

      // Pause frames count even while the port is locked
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          txUni_q[g] <= CNT_RESET;
        end else begin
          txUni_q[g] <= txUni_q[g] + DATA_W'(deq[g])
                        + DATA_W'(pauseSent[g]);
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses read zero, no lockup flag exists
  always_comb begin
    rd_d = '0;
    unique case (regReq.addr)
      ADDR_TAG0: rd_d[7:0] = defTag0_q;
      ADDR_TAG1: rd_d[7:0] = defTag1_q;
      ADDR_SOFT_RESET: rd_d[SOFT_RESET_BIT] = softReset_q;
      ADDR_LOOKUP_CTRL: rd_d[7:0] = lookupCtrl_q;
      ADDR_PM_USAGE: rd_d[FREE_LSB +: BLK_W] = free_q;
      default: begin
        for (int p = 0; p < NP; p++) begin
          if (portHit(regReq.addr, p, PORT_RX_DISCARD)) begin
            rd_d = rxDrop_q[p];
          end
          if (portHit(regReq.addr, p, PORT_TX_DISCARD)) begin
            rd_d = txDrop_q[p];
          end
          if (portHit(regReq.addr, p, PORT_TX_UNICAST)) begin
            rd_d = txUni_q[p];
          end
          if (portHit(regReq.addr, p, PORT_TXQ_USAGE)) begin
            rd_d[TXQ_LSB +: BLK_W] = used_q[p];
          end
        end
      end
    endcase
  end

  // Reads answer one cycle later; for the absent alarm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= regReq.rdEn;
    end
  end

  // Data reads zero between answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= regReq.rdEn ? rd_d : '0;
    end
  end
endmodule

/* verif/ptlm_lockup_asserts.sv */
// Port-level checker of the transmit lockup monitor
module ptlm_lockup_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire ptlm_pkg::ptlm_reg_req_t regReq,
  input wire logic [ptlm_pkg::DATA_W-1:0] rdData,
  input wire logic rdValid,
  input wire ptlm_pkg::ptlm_frame_t ingress,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] halfDuplex,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] lockupTrigger,
  input wire logic [ptlm_pkg::NUM_PORTS-1:0] txEnable,
  input wire logic fwdBlocked
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptlm_pkg::*;
  logic vlanQ;
  logic softQ;
  logic [NUM_PORTS-1:0] cause;
  assign cause = lockupTrigger & halfDuplex & {NUM_PORTS{vlanQ}};
  // Shadows of the VLAN enable and soft reset bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vlanQ <= 1'b0;
    end else if (regReq.wrEn && regReq.addr == ADDR_LOOKUP_CTRL) begin
      vlanQ <= regReq.wrData[VLAN_ENABLE_BIT];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      softQ <= 1'b0;
    end else if (regReq.wrEn && regReq.addr == ADDR_SOFT_RESET) begin
      softQ <= regReq.wrData[SOFT_RESET_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_lock_on_cause: assert property (
    cause != '0 && !softQ |=> (txEnable & $past(cause)) == '0)
    else $error("port not halted on lockup cause");
  chk_no_spurious: assert property (
    (~txEnable & $past(txEnable) & ~$past(cause)) == '0)
    else $error("port halted without cause");
  chk_lock_holds: assert property (
    !softQ |=> (txEnable & ~$past(txEnable)) == '0)
    else $error("halted port resumed without reset");
  chk_read_answer: assert property (regReq.rdEn |=> rdValid)
    else $error("read not answered");
  chk_no_stray: assert property (rdValid |-> $past(regReq.rdEn))
    else $error("answer without read");
  chk_data_idle: assert property (!rdValid |-> rdData == '0)
    else $error("read data not idle");
  chk_soft_frees: assert property (softQ [*2] |=> !fwdBlocked)
    else $error("forwarding blocked during soft reset");
  chk_reset_state: assert property (
    $fell(rst) |-> txEnable == '1 && !fwdBlocked)
    else $error("bad state after reset");
  chk_block_cause: assert property (
    $rose(fwdBlocked) |-> $past(ingress.valid))
    else $error("forwarding blocked without ingress");
  cover property (cause != '0);
  cover property (softQ && fwdBlocked);
  cover property ($rose(fwdBlocked));
  cover property ($fell(softQ));
endmodule

bind ptlm_port_tx_lockup_monitor ptlm_lockup_asserts u_chk (.clk(clk), .rst(rst),
  .regReq(regReq), .rdData(rdData), .rdValid(rdValid), .ingress(ingress),
  .halfDuplex(halfDuplex), .lockupTrigger(lockupTrigger), .txEnable(txEnable),
  .fwdBlocked(fwdBlocked));

/* verif/ptlm_host.sv */
// Management host model that polls the switch registers
module ptlm_host (
  input wire logic clk,
  output ptlm_pkg::ptlm_reg_req_t regReq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptlm_pkg::*;
  initial regReq = '0;
  // One-cycle strobe; address and data scrambled once released
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    regReq <= '{wr, !wr, a, d};
    @(negedge clk);
    regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic soft_reset();
    access(1'b1, ADDR_SOFT_RESET, 32'h0000_0001);
    access(1'b1, ADDR_SOFT_RESET, 32'h0000_0000);
  endtask
endmodule

/* verif/tb_port_tx_lockup_monitor.sv */
// Self-checking bench of the transmit lockup monitor
module tb_port_tx_lockup_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import ptlm_pkg::*;
  logic clk = 0;
  logic rst = 1;
  ptlm_reg_req_t regReq;
  logic [31:0] rdData;
  logic rdValid;
  ptlm_frame_t ingress = '0;
  logic [6:0] halfDuplex = 7'h06;
  logic [6:0] lockupTrigger = '0;
  logic [6:0] txSlot = '0;
  logic [6:0] pauseSent = '0;
  logic [6:0] txEnable;
  logic fwdBlocked;
  logic [31:0] expQ[$];
  logic [31:0] seed = 32'h25c7_8b28;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  always #2.5 clk = ~clk;
  ptlm_host host (.clk(clk), .regReq(regReq));
  ptlm_port_tx_lockup_monitor DUT (.clk(clk), .rst(rst), .regReq(regReq), .rdData(rdData),
    .rdValid(rdValid), .ingress(ingress), .halfDuplex(halfDuplex),
    .lockupTrigger(lockupTrigger), .txSlot(txSlot), .pauseSent(pauseSent),
    .txEnable(txEnable), .fwdBlocked(fwdBlocked));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] pa(input int p, input logic [11:0] off);
    return {4'(p), off};
  endfunction
  function automatic logic [31:0] fr(input logic [10:0] b);
    return {5'h00, b, 16'h0000};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_port(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t port enables %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t forwarding flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    expQ.push_back(e);
    host.access(1'b0, a, 32'h0000_0000);
  endtask
  task automatic send(input logic [2:0] s, input logic [2:0] d);
    @(negedge clk);
    ingress <= '{1'b1, s, d};
    @(negedge clk);
    ingress <= '0;
  endtask
  task automatic pls(input int k, input logic [6:0] m);
    @(negedge clk);
    if (k == 0) txSlot <= m;
    else if (k == 1) pauseSent <= m;
    else lockupTrigger <= m;
    @(negedge clk);
    {txSlot, pauseSent, lockupTrigger} <= '0;
  endtask
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        n_fail++;
        $display("[FAIL] %0t read answer without request", $time);
      end else cmp(rdData, expQ.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 0;
    rd(ADDR_PM_USAGE, fr(FREE_BLOCKS_IDLE));
    rd(pa(3, PORT_TXQ_USAGE), 32'h0000_0000);
    rd(16'h0002, 32'h0000_0000);
    host.access(1'b1, ADDR_TAG0, 32'h0000_0055);
    n = 1 + seed[2:0];
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      send(3'(1 + seed[7:0] % 7), 3'h3);
    end
    rd(pa(3, PORT_TXQ_USAGE), 32'(n));
    rd(ADDR_PM_USAGE, fr(FREE_BLOCKS_IDLE - 11'(n)));
    repeat (n) pls(0, 7'h04);
    rd(pa(3, PORT_TX_UNICAST), 32'(n));
    pls(2, 7'h06);
    cmp_port(txEnable, 7'h7f);
    host.access(1'b1, ADDR_LOOKUP_CTRL, 32'h0000_0080);
    pls(2, 7'h0c);
    cmp_port(txEnable, 7'h7b);
    pls(0, 7'h04);
    pls(1, 7'h04);
    rd(pa(3, PORT_TX_UNICAST), 32'(n + 1));
    repeat (TXQ_CAPACITY + 1) send(3'h1, 3'h3);
    rd(pa(3, PORT_TXQ_USAGE), 32'(TXQ_CAPACITY));
    rd(pa(3, PORT_TXQ_USAGE), 32'(TXQ_CAPACITY));
    rd(pa(3, PORT_TX_DISCARD), 32'h0000_0001);
    rd(pa(2, PORT_TX_DISCARD), 32'h0000_0000);
    rd(pa(1, PORT_RX_DISCARD), 32'h0000_0000);
    rd(ADDR_PM_USAGE, fr(FREE_BLOCKS_IDLE - TXQ_CAPACITY));
    host.soft_reset();
    cmp_port(txEnable, 7'h7f);
    rd(ADDR_TAG0, 32'h0000_0000);
    rd(pa(3, PORT_TXQ_USAGE), 32'h0000_0000);
    rd(pa(3, PORT_TX_DISCARD), 32'h0000_0001);
    for (int i = 0; i < FREE_BLOCKS_IDLE; i++) send(3'h5, 3'(1 + i % 4));
    send(3'h5, 3'h6);
    cmp_flag(fwdBlocked, 1'b1);
    rd(pa(5, PORT_RX_DISCARD), 32'h0000_0001);
    rd(pa(6, PORT_TX_DISCARD), 32'h0000_0000);
    rd(pa(6, PORT_TXQ_USAGE), 32'h0000_0000);
    host.soft_reset();
    cmp_flag(fwdBlocked, 1'b0);
    rd(ADDR_PM_USAGE, fr(FREE_BLOCKS_IDLE));
    pls(2, 7'h04);
    cmp_port(txEnable, 7'h7b);
    @(negedge clk) rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    cmp_port(txEnable, 7'h7f);
    rd(pa(3, PORT_TX_DISCARD), 32'h0000_0000);
    rd(ADDR_LOOKUP_CTRL, 32'h0000_0000);
    repeat (4) @(negedge clk);
    finish_test();
  end
endmodule
